//--- core/dsts_top.sv
// Detector status word, alarm contacts and test mode register logic
`timescale 1ns/1ns
`default_nettype none
`include "dsts_cfg.svh"

module dsts_top
  import dsts_pkg::*;
#(
  // Clock cycles per base tick (one millisecond)
  parameter int unsigned TICK_CYCLES =
    `DSTS_TICK_PERIOD_US * `DSTS_NS_PER_US / `DSTS_CLK_PERIOD_NS,
  // Base ticks until test mode ends
  parameter int unsigned TEST_TIMEOUT_TICKS =
    `DSTS_TEST_TIMEOUT_MIN * `DSTS_US_PER_MIN / `DSTS_TICK_PERIOD_US
)(
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst_b,
  // Measurement and alarm settings, same clock domain
  input  wire logic [15:0] i_concentration,
  input  wire logic [15:0] i_first_stage_threshold,
  input  wire logic [15:0] i_second_stage_threshold,
  input  wire logic [15:0] i_alarm_delay_ms,
  // Fault detector pins, asynchronous
  input  wire logic        i_flow_reduced,
  input  wire logic        i_flow_too_low,
  input  wire logic        i_heater_wire_open,
  input  wire logic        i_heater_fitted,
  input  wire logic        i_zero_output_low,
  input  wire logic        i_sensor_wire_open,
  input  wire logic        i_sensor_combustible,
  // Local test push switch, active high while pressed
  input  wire logic        i_test_switch,
  // Master register port
  input  wire logic [15:0] i_reg_addr,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [15:0] i_reg_wdata,
  output logic      [15:0] o_reg_rdata,
  output logic             o_reg_ack,
  // Alarm contacts and status
  output logic             o_first_stage_contact,
  output logic             o_second_stage_contact,
  output logic             o_test_mode,
  output logic      [15:0] o_status_word
);

  localparam int unsigned NPIN = 8;  // Synchronised pins

  // Refuse settings the counters cannot serve
  if (TICK_CYCLES < 2 || TICK_CYCLES > 65535) begin : g_bad_tick
    $error("TICK_CYCLES out of range");
  end
  if (TEST_TIMEOUT_TICKS < 1) begin : g_bad_timeout
    $error("TEST_TIMEOUT_TICKS must be at least one");
  end

  // Pin vector and its two-stage synchroniser
  logic [NPIN-1:0] pin_raw;    // Raw pins
  logic [NPIN-1:0] pin_meta;   // First stage, read only by second
  logic [NPIN-1:0] pin_sync;   // Second stage, safe to use

  assign pin_raw = {i_test_switch, i_sensor_combustible, i_sensor_wire_open,
                    i_zero_output_low, i_heater_fitted, i_heater_wire_open,
                    i_flow_too_low, i_flow_reduced};

  // One synchroniser per pin
  for (genvar g = 0; g < NPIN; g++) begin : g_sync
    always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
        pin_meta[g] <= 1'b0;
        pin_sync[g] <= 1'b0;
      end else begin
        pin_meta[g] <= pin_raw[g];
        pin_sync[g] <= pin_meta[g];
      end
    end
  end

  // Named views of the synchronised pins
  logic flow_reduced;   // Flow reduced
  logic flow_too_low;   // Flow too low
  logic heater_open;    // Heater wire open
  logic heater_fitted;  // Pyrolysis heater present
  logic zero_low;       // Sensor zero output extremely low
  logic wire_open;      // Sensor wire open
  logic combustible;    // Combustible sensor type
  logic switch_level;   // Test switch level

  assign flow_reduced  = pin_sync[0];
  assign flow_too_low  = pin_sync[1];
  assign heater_open   = pin_sync[2];
  assign heater_fitted = pin_sync[3];
  assign zero_low      = pin_sync[4];
  assign wire_open     = pin_sync[5];
  assign combustible   = pin_sync[6];
  assign switch_level  = pin_sync[7];

  // Base tick divider
  logic [15:0] div_cnt;       // Cycle count within a tick
  logic [15:0] next_div_cnt;  // Next cycle count
  logic        tick;          // One-cycle tick enable
  logic        next_tick;     // Next tick enable

  // Wrap the divider once per tick period
  always_comb begin
    next_tick    = 1'b0;
    next_div_cnt = div_cnt + 16'h0001;
    if (div_cnt == TICK_CYCLES[15:0] - 16'h0001) begin
      next_div_cnt = 16'h0000;
      next_tick    = 1'b1;
    end
  end

  // Divider registers
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      div_cnt <= 16'h0000;
      tick    <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      tick    <= next_tick;
    end
  end

  // Two alarm stages, index 0 second stage, index 1 first stage
  logic [1:0] stage_alarm;  // Qualified alarms

  for (genvar s = 0; s < 2; s++) begin : g_stage
    dsts_stage_if stg ();
    assign stg.level     = i_concentration;
    assign stg.threshold = (s == 0) ? i_second_stage_threshold : i_first_stage_threshold;
    assign stg.delay     = i_alarm_delay_ms;
    assign stg.tick      = tick;
    assign stage_alarm[s] = stg.alarm;
    dsts_alarm_delay u_stage (
      .i_clock (i_clock),
      .i_rst_b (i_rst_b),
      .stage   (stg.stage)
    );
  end

  // Trouble flags follow the fault conditions directly
  logic [3:0] trouble;  // {reduced, too low, heater, sensor}

  assign trouble[3] = flow_reduced;
  assign trouble[2] = flow_too_low;
  assign trouble[1] = heater_open & heater_fitted;
  assign trouble[0] = zero_low | (combustible & wire_open);

  // Register port decode
  logic wr_ctrl;   // Write to test mode control
  logic wr_level;  // Write to test level setting

  assign wr_ctrl  = i_reg_wr && (i_reg_addr == `DSTS_ADDR_TEST_CTRL);
  assign wr_level = i_reg_wr && (i_reg_addr == `DSTS_ADDR_LEVEL_SET);

  // Test mode timer
  dsts_test_if tmr ();
  logic test_on;        // Test mode state
  logic next_test_on;   // Next test mode state
  logic next_start;     // Entry into test mode this cycle

  assign tmr.tick    = tick;
  assign tmr.start   = next_start;
  assign tmr.running = test_on;

  dsts_test_timer #(
    .TIMEOUT_TICKS (TEST_TIMEOUT_TICKS)
  ) u_timer (
    .i_clock (i_clock),
    .i_rst_b (i_rst_b),
    .tmr     (tmr.timer)
  );

  // Test mode and level state
  logic       switch_prev;      // Switch level last cycle
  logic       press;            // Press event
  dsts_word_t test_level;       // Test gas concentration
  dsts_word_t next_test_level;  // Next test level

  assign press = switch_level & ~switch_prev;

  // An on or off master write wins over a switch press, which wins over the timeout
  always_comb begin
    next_test_on    = test_on;
    next_test_level = test_level;
    if (wr_ctrl && (i_reg_wdata == `DSTS_CTRL_ON)) begin
      next_test_on = 1'b1;
    end else if (wr_ctrl && (i_reg_wdata == `DSTS_CTRL_OFF)) begin
      next_test_on = 1'b0;
    end else if (press) begin
      // Each press flips the mode
      next_test_on = ~test_on;
    end else if (tmr.expired) begin
      next_test_on = 1'b0;
    end
    // Out-of-range levels are dropped, keeping the last good one
    if (wr_level && (i_reg_wdata >= `DSTS_LEVEL_MIN) && (i_reg_wdata <= `DSTS_LEVEL_MAX)) begin
      next_test_level = i_reg_wdata;
    end
    // Timer restarts only on an off-to-on change
    next_start = next_test_on & ~test_on;
  end

  // Test registers
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      test_on     <= 1'b0;
      test_level  <= `DSTS_LEVEL_RESET;
      switch_prev <= 1'b0;
    end else begin
      test_on     <= next_test_on;
      test_level  <= next_test_level;
      switch_prev <= switch_level;
    end
  end

  // Status word and outputs
  dsts_word_t next_status;  // Assembled status word
  dsts_word_t next_rdata;   // Read data for this request
  logic       next_ack;     // Acknowledge for this request

  // Pack the flags, everything else stays zero
  always_comb begin
    next_status = 16'h0000;
    // Byte one is the high byte, byte two the low byte
    next_status[`DSTS_BIT_FIRST_STAGE]  = stage_alarm[1];
    next_status[`DSTS_BIT_SECOND_STAGE] = stage_alarm[0];
    // Trouble bits clear as soon as the fault is gone
    next_status[`DSTS_BIT_FLOW_REDUCED] = trouble[3];
    next_status[`DSTS_BIT_FLOW_LOW]     = trouble[2];
    next_status[`DSTS_BIT_HEATER_OPEN]  = trouble[1];
    next_status[`DSTS_BIT_SENSOR_FAULT] = trouble[0];
    next_status[`DSTS_BIT_TEST_MODE]    = test_on;
  end

  // Read mux; write-only and unknown addresses read zero
  always_comb begin
    next_ack   = i_reg_rd | i_reg_wr;
    next_rdata = 16'h0000;
    if (i_reg_rd) begin
      case (i_reg_addr)
        `DSTS_ADDR_TEST_STATE: next_rdata = {15'h0000, test_on};
        `DSTS_ADDR_TEST_LEVEL: next_rdata = test_level;
        `DSTS_ADDR_STATUS:     next_rdata = o_status_word;
        default:               next_rdata = 16'h0000;
      endcase
    end
  end

  // Output registers; contacts also forced by test mode
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_status_word          <= 16'h0000;
      o_reg_rdata            <= 16'h0000;
      o_reg_ack              <= 1'b0;
      o_first_stage_contact  <= 1'b0;
      o_second_stage_contact <= 1'b0;
      o_test_mode            <= 1'b0;
    end else begin
      o_status_word          <= next_status;
      o_reg_rdata            <= next_rdata;
      o_reg_ack              <= next_ack;
      o_first_stage_contact  <= stage_alarm[1] | test_on;
      o_second_stage_contact <= stage_alarm[0] | test_on;
      o_test_mode            <= test_on;
    end
  end

endmodule

`default_nettype wire

//--- core/dsts_cfg.svh
// Constants for the detector status and test mode block
`ifndef DSTS_CFG_SVH
`define DSTS_CFG_SVH

// Register addresses of the master port
`define DSTS_ADDR_TEST_STATE   16'h9c51
`define DSTS_ADDR_TEST_LEVEL   16'h9c52
`define DSTS_ADDR_TEST_CTRL    16'h9c70
`define DSTS_ADDR_LEVEL_SET    16'h9c71
`define DSTS_ADDR_STATUS       16'h9e44

// Control codes and level limits
`define DSTS_CTRL_ON           16'h0001
`define DSTS_CTRL_OFF          16'h0000
`define DSTS_LEVEL_MIN         16'h0001
`define DSTS_LEVEL_MAX         16'h0064
`define DSTS_LEVEL_RESET       16'h0001

// Status word bit positions
`define DSTS_BIT_SECOND_STAGE  8
`define DSTS_BIT_FIRST_STAGE   9
`define DSTS_BIT_SENSOR_FAULT  10
`define DSTS_BIT_HEATER_OPEN   11
`define DSTS_BIT_FLOW_LOW      12
`define DSTS_BIT_FLOW_REDUCED  13
`define DSTS_BIT_TEST_MODE     2

// Timing: clock period, base tick and test timeout
`define DSTS_CLK_PERIOD_NS     50
`define DSTS_TICK_PERIOD_US    1000
`define DSTS_NS_PER_US         1000
`define DSTS_US_PER_MIN        60000000
`define DSTS_TEST_TIMEOUT_MIN  10

`endif

//--- core/dsts_pkg.sv
// Types shared by the detector status and test mode block
package dsts_pkg;

  // Alarm stage qualification states
  typedef enum logic [1:0] {
    DSTS_ST_IDLE  = 2'b00,
    DSTS_ST_WAIT  = 2'b01,
    DSTS_ST_ALARM = 2'b10
  } dsts_stage_e;

  // Register word
  typedef logic [15:0] dsts_word_t;

endpackage

//--- core/dsts_if.sv
// Interfaces between the top and its alarm stage and test timer modules
`timescale 1ns/1ns
`default_nettype none

// One gas alarm stage: measurement in, qualified alarm out
interface dsts_stage_if;
  logic [15:0] level;      // Measured concentration
  logic [15:0] threshold;  // Alarm set value
  logic [15:0] delay;      // Delay in base ticks
  logic        tick;       // Base tick enable
  logic        alarm;      // Qualified alarm
  modport stage (input level, threshold, delay, tick, output alarm);
  modport ctrl  (output level, threshold, delay, tick, input alarm);
endinterface

// Test mode timeout timer
interface dsts_test_if;
  logic tick;     // Base tick enable
  logic start;    // Restart on entry to test mode
  logic running;  // Test mode currently on
  logic expired;  // One-cycle pulse at timeout
  modport timer (input tick, start, running, output expired);
  modport ctrl  (output tick, start, running, input expired);
endinterface

`default_nettype wire

//--- core/dsts_alarm_delay.sv
// Gas alarm stage with entry delay and self-clearing exit
`timescale 1ns/1ns
`default_nettype none
`include "dsts_cfg.svh"

module dsts_alarm_delay
  import dsts_pkg::*;
(
  // Clock and reset
  input  wire logic  i_clock,
  input  wire logic  i_rst_b,
  // Stage carrier
  dsts_stage_if.stage stage
);

  dsts_stage_e state;       // Current stage state
  dsts_stage_e next_state;  // Next stage state
  logic [15:0] cnt;         // Delay ticks elapsed
  logic [15:0] next_cnt;    // Next tick count

  // Next state: qualify exceedance over the delay, drop below threshold
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    case (state)
      DSTS_ST_IDLE: begin
        next_cnt = 16'h0000;
        if (stage.level > stage.threshold) begin
          // Zero delay alarms at once
          next_state = (stage.delay == 16'h0000) ? DSTS_ST_ALARM : DSTS_ST_WAIT;
        end
      end
      DSTS_ST_WAIT: begin
        if (stage.level <= stage.threshold) begin
          // Exceedance lost, delay restarts next time
          next_state = DSTS_ST_IDLE;
        end else if (stage.tick) begin
          next_cnt = cnt + 16'h0001;
          // First tick after entry may be partial; one extra tick guarantees the full delay
          if (cnt >= stage.delay) begin
            next_state = DSTS_ST_ALARM;
          end
        end
      end
      DSTS_ST_ALARM: begin
        // No acknowledge needed, clears on its own
        if (stage.level < stage.threshold) begin
          next_state = DSTS_ST_IDLE;
        end
      end
      default: begin
        next_state = DSTS_ST_IDLE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= DSTS_ST_IDLE;
      cnt   <= 16'h0000;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  assign stage.alarm = (state == DSTS_ST_ALARM);

endmodule

`default_nettype wire

//--- core/dsts_test_timer.sv
// Test mode timeout timer counting base ticks
`timescale 1ns/1ns
`default_nettype none
`include "dsts_cfg.svh"

module dsts_test_timer
  import dsts_pkg::*;
#(
  parameter int unsigned TIMEOUT_TICKS = 600000  // Ticks until test mode ends
)(
  // Clock and reset
  input  wire logic  i_clock,
  input  wire logic  i_rst_b,
  // Timer carrier
  dsts_test_if.timer tmr
);

  logic [31:0] cnt;           // Ticks since entry
  logic [31:0] next_cnt;      // Next tick count
  logic        expired;       // Timeout pulse
  logic        next_expired;  // Next timeout pulse

  // Count while running, restart on entry
  always_comb begin
    next_cnt     = cnt;
    next_expired = 1'b0;
    if (tmr.start || !tmr.running) begin
      next_cnt = 32'h0000_0000;
    end else if (tmr.tick) begin
      if (cnt == TIMEOUT_TICKS[31:0] - 32'h0000_0001) begin
        // Fire once, then count again from zero while the mode stays on
        next_expired = 1'b1;
        next_cnt     = 32'h0000_0000;
      end else begin
        next_cnt = cnt + 32'h0000_0001;
      end
    end
  end

  // Timer registers
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt     <= 32'h0000_0000;
      expired <= 1'b0;
    end else begin
      cnt     <= next_cnt;
      expired <= next_expired;
    end
  end

  assign tmr.expired = expired;

endmodule

`default_nettype wire

//--- tb/dsts_master.sv
// Register master model that polls and writes the detector block
`timescale 1ns/1ns
`default_nettype none

module dsts_master (
  // Clock
  input  wire logic        i_clock,
  // Answer from the device
  input  wire logic [15:0] i_reg_rdata,
  input  wire logic        i_reg_ack,
  // Request to the device
  output logic      [15:0] o_reg_addr,
  output logic             o_reg_wr,
  output logic             o_reg_rd,
  output logic      [15:0] o_reg_wdata
);
  // Idle bus at time zero
  initial begin
    o_reg_addr = 16'h0000;
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_wdata = 16'h0000;
  end

  // One word transfer; ok stays low if no ack came in four edges
  task automatic xfer(input logic wr, input logic [15:0] addr, data,
                      output logic [15:0] rd, output logic ok);
    ok = 1'b0;
    rd = 16'h0000;
    @(posedge i_clock);
    o_reg_addr <= addr;
    o_reg_wdata <= data;
    o_reg_wr <= wr;
    o_reg_rd <= !wr;
    @(posedge i_clock);
    // Strobe is a one-cycle pulse; address and data stand until the ack
    o_reg_wr <= 1'b0;
    o_reg_rd <= 1'b0;
    for (int k = 0; k < 4 && !ok; k++) begin
      @(posedge i_clock);
      if (i_reg_ack === 1'b1) begin
        ok = 1'b1;
        rd = i_reg_rdata;
      end
    end
    // Released lines show garbage
    o_reg_addr <= ~addr;
    o_reg_wdata <= ~data;
  endtask
endmodule

`default_nettype wire

//--- tb/dsts_assertions.sv
// Port-level checks of the detector status and test mode block
`timescale 1ns/1ns
`default_nettype none
`include "dsts_cfg.svh"

module dsts_checker #(
  parameter int unsigned TICK_CYCLES        = 4,
  parameter int unsigned TEST_TIMEOUT_TICKS = 5
)(
  input  wire logic        i_clock,
  input  wire logic        i_rst_b,
  input  wire logic [15:0] i_concentration,
  input  wire logic [15:0] i_first_stage_threshold,
  input  wire logic        i_flow_reduced,
  input  wire logic        i_heater_wire_open,
  input  wire logic        i_heater_fitted,
  input  wire logic [15:0] i_reg_addr,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [15:0] i_reg_wdata,
  input  wire logic [15:0] o_reg_rdata,
  input  wire logic        o_reg_ack,
  input  wire logic        o_first_stage_contact,
  input  wire logic        o_second_stage_contact,
  input  wire logic        o_test_mode,
  input  wire logic [15:0] o_status_word
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);

  // Cycles spent in test mode, cleared whenever it is off
  int unsigned on_cnt;
  int unsigned next_on_cnt;
  wire logic   wr_ctrl = i_reg_wr && (i_reg_addr == `DSTS_ADDR_TEST_CTRL);

  // Next count
  always_comb begin
    next_on_cnt = o_test_mode ? on_cnt + 1 : 0;
  end

  // Count register
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) on_cnt <= 0;
    else on_cnt <= next_on_cnt;
  end

  ack_after_strobe_a: assert property ((i_reg_rd || i_reg_wr) |=> o_reg_ack)
    else $error("ack missing after strobe");
  ack_has_cause_a: assert property (o_reg_ack |-> $past(i_reg_rd || i_reg_wr))
    else $error("ack without strobe");
  rdata_idle_a: assert property (!o_reg_ack |-> o_reg_rdata == 16'h0000)
    else $error("read data outside ack");
  unused_bits_a: assert property ((o_status_word & 16'hc0fb) == 16'h0000)
    else $error("unassigned status bit set");
  test_contacts_a: assert property (o_test_mode |-> o_first_stage_contact && o_second_stage_contact)
    else $error("contacts off in test mode");
  test_bit_a: assert property ($rose(o_test_mode) |-> ##[0:1] o_status_word[2])
    else $error("test bit not shown");
  ctrl_on_a: assert property (wr_ctrl && i_reg_wdata == `DSTS_CTRL_ON |-> ##2 o_test_mode)
    else $error("test mode not on after write");
  ctrl_off_a: assert property (wr_ctrl && i_reg_wdata == `DSTS_CTRL_OFF |-> ##2 !o_test_mode)
    else $error("test mode not off after write");
  test_timeout_a: assert property (on_cnt <= TICK_CYCLES * (TEST_TIMEOUT_TICKS + 1) + 4)
    else $error("test mode outlived timeout");
  flow_flag_a: assert property (i_flow_reduced [*4] |-> o_status_word[13])
    else $error("reduced flow flag missing");
  fault_clear_a: assert property ((!i_flow_reduced) [*4] |-> !o_status_word[13])
    else $error("flow flag not cleared");
  heater_mask_a: assert property ((!i_heater_fitted || !i_heater_wire_open) [*4] |-> !o_status_word[11])
    else $error("heater flag without fitted heater");
  alarm_clear_a: assert property ((i_concentration < i_first_stage_threshold) [*4] |-> !o_status_word[9])
    else $error("first stage alarm not cleared");

  // Main scenarios reached
  timeout_c: cover property ($fell(o_test_mode) && on_cnt >= TICK_CYCLES * (TEST_TIMEOUT_TICKS - 1));
  alarm_c: cover property ($rose(o_status_word[9]));
  status_rd_c: cover property (i_reg_rd && i_reg_addr == `DSTS_ADDR_STATUS);
endmodule

bind dsts_top dsts_checker #(
  .TICK_CYCLES(TICK_CYCLES),
  .TEST_TIMEOUT_TICKS(TEST_TIMEOUT_TICKS)
) dsts_checker_inst (
  .i_clock, .i_rst_b, .i_concentration, .i_first_stage_threshold, .i_flow_reduced,
  .i_heater_wire_open, .i_heater_fitted, .i_reg_addr, .i_reg_wr, .i_reg_rd, .i_reg_wdata,
  .o_reg_rdata, .o_reg_ack, .o_first_stage_contact, .o_second_stage_contact, .o_test_mode,
  .o_status_word
);

`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench for the detector status and test mode block
`timescale 1ns/1ns
`default_nettype none
`include "dsts_cfg.svh"

module tb_top;
  logic        i_clock;
  logic        i_rst_b;
  logic        sw;           // Test push switch
  logic [15:0] conc;         // Measured level
  logic [15:0] dly;          // Alarm delay in ticks
  logic [6:0]  flt;          // Fault pins in port order
  logic [15:0] addr, wdata, rdata, status;
  logic        wr, rd, ack, c1, c2, tmode;
  logic [15:0] lv [5];       // Level writes
  logic [15:0] ex [5];       // Expected level readback
  logic [31:0] seed = 32'h0000_0880;
  int          mismatches;
  int          compares;

  dsts_top #(.TICK_CYCLES(4), .TEST_TIMEOUT_TICKS(5)) dsts_top_inst (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_concentration(conc),
    .i_first_stage_threshold(16'h0064), .i_second_stage_threshold(16'h00c8),
    .i_alarm_delay_ms(dly), .i_flow_reduced(flt[0]), .i_flow_too_low(flt[1]),
    .i_heater_wire_open(flt[2]), .i_heater_fitted(flt[3]), .i_zero_output_low(flt[4]),
    .i_sensor_wire_open(flt[5]), .i_sensor_combustible(flt[6]), .i_test_switch(sw),
    .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata),
    .o_reg_rdata(rdata), .o_reg_ack(ack), .o_first_stage_contact(c1),
    .o_second_stage_contact(c2), .o_test_mode(tmode), .o_status_word(status));

  dsts_master dsts_master_inst (
    .i_clock(i_clock), .i_reg_rdata(rdata), .i_reg_ack(ack),
    .o_reg_addr(addr), .o_reg_wr(wr), .o_reg_rd(rd), .o_reg_wdata(wdata));

  // 20 MHz clock
  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end

  // Repeatable xorshift source
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction

  // Status word worked out from fault pins, alarms and test state
  function automatic logic [15:0] exp_status(input logic [6:0] f, input logic a1, a2, t);
    logic [15:0] s;
    s = 16'h0000;
    s[13] = f[0];
    s[12] = f[1];
    s[11] = f[2] & f[3];
    s[10] = f[4] | (f[6] & f[5]);
    s[9] = a1;
    s[8] = a2;
    s[2] = t;
    return s;
  endfunction

  task automatic check(input logic [15:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Bus transfer; a missing ack ends the run
  task automatic xreg(input logic w, input logic [15:0] a, d, output logic [15:0] r);
    logic ok;
    dsts_master_inst.xfer(w, a, d, r, ok);
    if (!ok) begin
      mismatches++;
      give_verdict();
    end
  endtask

  task automatic wreg(input logic [15:0] a, d);
    logic [15:0] r;
    xreg(1'b1, a, d, r);
  endtask

  task automatic rchk(input logic [15:0] a, exp);
    logic [15:0] r;
    xreg(1'b0, a, 16'h0000, r);
    check(r, exp);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clock);
  endtask

  // Press held long enough for the synchroniser
  task automatic press();
    sw <= 1'b1;
    cyc(4);
    sw <= 1'b0;
    cyc(4);
  endtask

  initial begin
    i_rst_b = 1'b0;
    sw = 1'b0;
    conc = 16'h0000;
    dly = 16'h0002;
    flt = 7'h00;
    mismatches = 0;
    compares = 0;
    cyc(4);
    i_rst_b <= 1'b1;
    cyc(2);
    check(status, 16'h0000);
    rchk(`DSTS_ADDR_TEST_LEVEL, 16'h0001);
    // Levels at and beyond both ends of the range, then one at random
    lv = '{16'h0000, 16'h0001, 16'h0064, 16'h0065, rnd() % 100 + 1};
    ex = '{16'h0001, 16'h0001, 16'h0064, 16'h0064, lv[4]};
    foreach (lv[i]) begin
      wreg(`DSTS_ADDR_LEVEL_SET, lv[i]);
      rchk(`DSTS_ADDR_TEST_LEVEL, ex[i]);
    end
    // Write-only and unmapped places read zero; read-only writes ignored
    rchk(`DSTS_ADDR_TEST_CTRL, 16'h0000);
    rchk(16'h9c53, 16'h0000);
    wreg(`DSTS_ADDR_STATUS, 16'hffff);
    wreg(`DSTS_ADDR_TEST_CTRL, 16'h0002);
    rchk(`DSTS_ADDR_STATUS, 16'h0000);
    // Master on, repeated on, then off
    wreg(`DSTS_ADDR_TEST_CTRL, 16'h0001);
    cyc(1);
    check({13'h0, tmode, c1, c2}, 16'h0007);
    wreg(`DSTS_ADDR_TEST_CTRL, 16'h0001);
    rchk(`DSTS_ADDR_TEST_STATE, 16'h0001);
    check(status, exp_status(7'h00, 1'b0, 1'b0, 1'b1));
    wreg(`DSTS_ADDR_TEST_CTRL, 16'h0000);
    cyc(2);
    check({14'h0, tmode, c1}, 16'h0000);
    // Self-ending test mode
    wreg(`DSTS_ADDR_TEST_CTRL, 16'h0001);
    cyc(12);
    check({15'h0, tmode}, 16'h0001);
    for (int k = 0; k < 30 && tmode !== 1'b0; k++) cyc(1);
    check({15'h0, tmode}, 16'h0000);
    if (tmode !== 1'b0) give_verdict();
    // Local switch toggles on, then off
    press();
    check({15'h0, tmode}, 16'h0001);
    press();
    check({15'h0, tmode}, 16'h0000);
    // Fault pins: two hand cases, then random patterns
    for (int i = 0; i < 14; i++) begin
      flt <= (i == 0) ? 7'h24 : (i == 1) ? 7'h7f : rnd() % 128;
      cyc(5);
      check(status, exp_status(flt, 1'b0, 1'b0, 1'b0));
      rchk(`DSTS_ADDR_STATUS, exp_status(flt, 1'b0, 1'b0, 1'b0));
    end
    flt <= 7'h00;
    // Gas alarms: delay, both stages, self-clearing
    conc <= 16'h0096;
    cyc(8);
    check({15'h0, c1}, 16'h0000);
    cyc(10);
    check({14'h0, c1, c2}, 16'h0002);
    check(status, exp_status(7'h00, 1'b1, 1'b0, 1'b0));
    conc <= 16'h00fa;
    cyc(20);
    check({14'h0, c1, c2}, 16'h0003);
    check(status, exp_status(7'h00, 1'b1, 1'b1, 1'b0));
    conc <= 16'h0032;
    cyc(5);
    check({14'h0, c1, c2}, 16'h0000);
    check(status, 16'h0000);
    // Zero delay alarms without waiting for ticks, checked three cycles later
    dly <= 16'h0000;
    conc <= 16'h0096;
    cyc(3);
    check({14'h0, c1, c2}, 16'h0002);
    give_verdict();
  end
endmodule

`default_nettype wire
